// ### core/ctc_config_regs.sv
`timescale 1ns/1ps
`default_nettype none
`include "ctc_defs.svh"
module ctc_config_regs (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic wrStb,
   input wire logic rdStb,
   input wire logic [7:0] cmdCode,
   input wire logic [7:0] wrData,
   input wire ctc_pkg::ctc_margin_t marginReq,
   input wire logic enable,
   input wire logic outputUndervoltage,
   output logic [7:0] rdData,
   output logic rdValid,
   output logic rdErr,
   output logic [9:0] switchFreqKhz,
   output logic forcedContinuous,
   output logic softStartActive,
   output logic latchedOff,
   output logic [15:0] refScale
);
   import ctc_pkg::*;

   // Scale in units of 1/10000: trim 0.75 percent per step, codes clamped to 0x03..0x1c, except codes 0x0f and 0x10 both give 10000
   function automatic logic [15:0] trimScale(input logic [4:0] code);
      logic [4:0] c;
      c = code;
      if (c[4:2] == 3'b111) c = 5'h1c;
      if (c[4:2] == 3'b000) c = 5'h03;
      if (c >= 5'h10) trimScale = 16'(10000 + 75 * (c - 5'h10));
      else trimScale = 16'(10000 - 75 * (5'h0f - c));
   endfunction

   // Margin high percentages in units of 1/10000
   function automatic logic [15:0] marginHighScale(input logic [3:0] code);
      unique case (code)
         4'h0: marginHighScale = 16'd10000;
         4'h1: marginHighScale = 16'd10090;
         4'h2: marginHighScale = 16'd10180;
         4'h3: marginHighScale = 16'd10280;
         4'h4: marginHighScale = 16'd10370;
         4'h5: marginHighScale = 16'd10470;
         4'h6: marginHighScale = 16'd10570;
         4'h7: marginHighScale = 16'd10670;
         4'h8: marginHighScale = 16'd10770;
         4'h9: marginHighScale = 16'd10880;
         4'ha: marginHighScale = 16'd10990;
         4'hb: marginHighScale = 16'd11090;
         default: marginHighScale = 16'd11200;
      endcase
   endfunction

   // Margin low percentages in units of 1/10000
   function automatic logic [15:0] marginLowScale(input logic [3:0] code);
      unique case (code)
         4'h0: marginLowScale = 16'd10000;
         4'h1: marginLowScale = 16'd9890;
         4'h2: marginLowScale = 16'd9790;
         4'h3: marginLowScale = 16'd9680;
         4'h4: marginLowScale = 16'd9580;
         4'h5: marginLowScale = 16'd9480;
         4'h6: marginLowScale = 16'd9380;
         4'h7: marginLowScale = 16'd9290;
         4'h8: marginLowScale = 16'd9190;
         4'h9: marginLowScale = 16'd9100;
         4'ha: marginLowScale = 16'd9010;
         4'hb: marginLowScale = 16'd8930;
         default: marginLowScale = 16'd8840;
      endcase
   endfunction

   // Frequency code to kHz
   function automatic logic [9:0] freqKhz(input logic [2:0] code);
      unique case (code)
         3'd0: freqKhz = 10'd250;
         3'd1: freqKhz = 10'd300;
         3'd2: freqKhz = 10'd400;
         3'd3: freqKhz = 10'd500;
         3'd4: freqKhz = 10'd600;
         3'd5: freqKhz = 10'd750;
         3'd6: freqKhz = 10'd850;
         default: freqKhz = 10'd1000;
      endcase
   endfunction

   localparam logic [31:0] SsBaseCyc = 32'(`CTC_US_CYCLES(`CTC_SS_BASE_US));
   localparam logic [31:0] HiccupBaseCyc = 32'(`CTC_US_CYCLES(`CTC_HICCUP_BASE_US));
   localparam logic [11:0] StepBaseCyc = 12'(`CTC_US_CYCLES(`CTC_STEP_BASE_US));
   localparam logic [12:0] ProcCyc = 13'(`CTC_US_CYCLES(`CTC_PROC_DELAY_US));

   logic [7:0] modeReg, modeNext, freqReg, freqNext, trimReg, trimNext, marginReg, marginNext;
   logic [7:0] rdDataReg, rdDataNext;
   logic rdValidReg, rdValidNext, rdErrReg, rdErrNext;

   // Register write and read path
   always_comb begin
      modeNext = modeReg;
      freqNext = freqReg;
      trimNext = trimReg;
      marginNext = marginReg;
      rdDataNext = 8'h00;
      rdValidNext = 1'b0;
      rdErrNext = 1'b0;
      if (wrStb) begin
         unique case (cmdCode)
            `CTC_CMD_MODE: modeNext = wrData & `CTC_MODE_MASK;
            `CTC_CMD_FREQ: freqNext = wrData & `CTC_FREQ_MASK;
            `CTC_CMD_TRIM: trimNext = wrData & `CTC_TRIM_MASK;
            `CTC_CMD_MARGIN: marginNext = wrData & `CTC_MARGIN_MASK;
            default: ;
         endcase
      end
      if (rdStb) begin
         rdValidNext = 1'b1;
         unique case (cmdCode)
            `CTC_CMD_MODE: rdDataNext = modeReg;
            `CTC_CMD_FREQ: rdDataNext = freqReg;
            `CTC_CMD_TRIM: rdDataNext = trimReg;
            `CTC_CMD_MARGIN: rdDataNext = marginReg;
            default: rdErrNext = 1'b1;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         modeReg <= `CTC_MODE_RST;
         freqReg <= `CTC_FREQ_RST;
         trimReg <= `CTC_TRIM_RST;
         marginReg <= `CTC_MARGIN_RST;
         rdDataReg <= 8'h00;
         rdValidReg <= 1'b0;
         rdErrReg <= 1'b0;
      end else begin
         modeReg <= modeNext;
         freqReg <= freqNext;
         trimReg <= trimNext;
         marginReg <= marginNext;
         rdDataReg <= rdDataNext;
         rdValidReg <= rdValidNext;
         rdErrReg <= rdErrNext;
      end
   end

   // Start-up sequencer: ramp, run, hiccup wait or latch-off
   ctc_state_t stateReg, stateNext;
   logic [1:0] ssSelReg, ssSelNext;
   logic uvRespReg, uvRespNext;
   logic [31:0] seqCntReg, seqCntNext;
   logic fccmReg, fccmNext, latchReg, latchNext, ssActReg, ssActNext;
   logic [31:0] rampCyc;
   logic [9:0] freqOutReg;

   always_comb begin
      rampCyc = SsBaseCyc << ssSelReg;
      stateNext = stateReg;
      ssSelNext = ssSelReg;
      uvRespNext = uvRespReg;
      seqCntNext = seqCntReg;
      fccmNext = fccmReg;
      latchNext = latchReg;
      unique case (stateReg)
         CTC_OFF: begin
            latchNext = 1'b0;
            if (enable) begin
               stateNext = CTC_RAMP;
               ssSelNext = modeReg[`CTC_RAMP_HI:`CTC_RAMP_LO];
               uvRespNext = modeReg[`CTC_UVRESP_BIT];
               seqCntNext = 32'd0;
               fccmNext = 1'b0;
            end
         end
         CTC_RAMP: begin
            fccmNext = 1'b0;
            seqCntNext = seqCntReg + 32'd1;
            if (seqCntReg + 32'd1 >= rampCyc) begin
               stateNext = CTC_RUN;
               fccmNext = modeReg[`CTC_COND_BIT];
            end
         end
         CTC_RUN: begin
            fccmNext = modeReg[`CTC_COND_BIT];
            if (outputUndervoltage) begin
               seqCntNext = 32'd0;
               fccmNext = 1'b0;
               if (uvRespReg) begin
                  stateNext = CTC_OFF;
                  latchNext = 1'b1;
               end else stateNext = CTC_WAIT;
            end
         end
         CTC_WAIT: begin
            seqCntNext = seqCntReg + 32'd1;
            if (seqCntReg + 32'd1 >= HiccupBaseCyc + 32'(`CTC_HICCUP_MULT) * rampCyc) begin
               stateNext = CTC_RAMP;
               ssSelNext = modeReg[`CTC_RAMP_HI:`CTC_RAMP_LO];
               uvRespNext = modeReg[`CTC_UVRESP_BIT];
               seqCntNext = 32'd0;
            end
         end
      endcase
      if (latchReg) begin
         stateNext = CTC_OFF;
         latchNext = enable; // Latched until enable drops
      end else if (!enable) begin
         stateNext = CTC_OFF;
         fccmNext = 1'b0;
      end
      ssActNext = (stateNext == CTC_RAMP);
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         stateReg <= CTC_OFF;
         ssSelReg <= 2'd0;
         uvRespReg <= 1'b0;
         seqCntReg <= 32'd0;
         fccmReg <= 1'b0;
         latchReg <= 1'b0;
         ssActReg <= 1'b0;
         freqOutReg <= 10'd400;
      end else begin
         stateReg <= stateNext;
         ssSelReg <= ssSelNext;
         uvRespReg <= uvRespNext;
         seqCntReg <= seqCntNext;
         fccmReg <= fccmNext;
         latchReg <= latchNext;
         ssActReg <= ssActNext;
         freqOutReg <= freqKhz(freqReg[2:0]);
      end
   end

   // Reference slew: delayed start, then one step per interval
   logic [15:0] targetScale, scaleReg, scaleNext;
   logic [31:0] product;
   logic [12:0] procCntReg, procCntNext;
   logic [11:0] stepCntReg, stepCntNext;
   logic [11:0] stepCyc;
   logic [7:0] trimSeenReg, marginSeenReg;
   ctc_margin_t margSeenReg;
   logic changed;

   always_comb begin
      unique case (marginReq)
         CTC_MARG_HIGH: product = 32'(trimScale(trimReg[4:0])) * 32'(marginHighScale(marginReg[7:4]));
         CTC_MARG_LOW: product = 32'(trimScale(trimReg[4:0])) * 32'(marginLowScale(marginReg[3:0]));
         default: product = 32'(trimScale(trimReg[4:0])) * 32'd10000;
      endcase
      targetScale = 16'(product / 32'd10000);
      stepCyc = StepBaseCyc << modeReg[`CTC_RAMP_HI:`CTC_RAMP_LO];
      changed = (trimReg != trimSeenReg) || (marginReg != marginSeenReg) || (marginReq != margSeenReg);
      scaleNext = scaleReg;
      procCntNext = procCntReg;
      stepCntNext = stepCntReg;
      if (changed) procCntNext = ProcCyc;
      else if (procCntReg != 13'd0) procCntNext = procCntReg - 13'd1;
      else if (scaleReg != targetScale) begin
         if (stepCntReg + 12'd1 >= stepCyc) begin
            stepCntNext = 12'd0;
            scaleNext = (scaleReg < targetScale) ? scaleReg + 16'd1 : scaleReg - 16'd1;
         end else stepCntNext = stepCntReg + 12'd1;
      end else stepCntNext = 12'd0;
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         scaleReg <= 16'd10000;
         procCntReg <= 13'd0;
         stepCntReg <= 12'd0;
         trimSeenReg <= `CTC_TRIM_RST;
         marginSeenReg <= `CTC_MARGIN_RST;
         margSeenReg <= CTC_MARG_NONE;
      end else begin
         scaleReg <= scaleNext;
         procCntReg <= procCntNext;
         stepCntReg <= stepCntNext;
         trimSeenReg <= trimReg;
         marginSeenReg <= marginReg;
         margSeenReg <= marginReq;
      end
   end

   assign rdData = rdDataReg;
   assign rdValid = rdValidReg;
   assign rdErr = rdErrReg;
   assign switchFreqKhz = freqOutReg;
   assign forcedContinuous = fccmReg;
   assign softStartActive = ssActReg;
   assign latchedOff = latchReg;
   assign refScale = scaleReg;
endmodule // ctc_config_regs
`default_nettype wire

// ### core/ctc_defs.svh
`ifndef CTC_DEFS_SVH
`define CTC_DEFS_SVH
// Command codes of the configuration registers
`define CTC_CMD_MODE 8'hd2
`define CTC_CMD_FREQ 8'hd3
`define CTC_CMD_TRIM 8'hd4
`define CTC_CMD_MARGIN 8'hd5
// Field positions
`define CTC_RAMP_HI 3
`define CTC_RAMP_LO 2
`define CTC_UVRESP_BIT 1
`define CTC_COND_BIT 0
// Reset values
`define CTC_MODE_RST 8'h00
`define CTC_FREQ_RST 8'h02
`define CTC_TRIM_RST 8'h10
`define CTC_MARGIN_RST 8'h55
// Writable bit masks; unsupported bits ignored
`define CTC_MODE_MASK 8'h0f
`define CTC_FREQ_MASK 8'h07
`define CTC_TRIM_MASK 8'h1f
`define CTC_MARGIN_MASK 8'hff
// Timing at 100 MHz
`define CTC_CLK_NS 10
`define CTC_SS_BASE_US 1000
`define CTC_HICCUP_BASE_US 8960
`define CTC_HICCUP_MULT 7
`define CTC_STEP_BASE_US 4
`define CTC_PROC_DELAY_US 50
`define CTC_US_CYCLES(us) ((us) * 1000 / `CTC_CLK_NS)
`endif

// ### core/ctc_pkg.sv
`default_nettype none
package ctc_pkg;
   typedef enum logic [1:0] {CTC_OFF, CTC_RAMP, CTC_RUN, CTC_WAIT} ctc_state_t;
   typedef enum logic [1:0] {CTC_MARG_NONE, CTC_MARG_HIGH, CTC_MARG_LOW} ctc_margin_t;
endpackage
`default_nettype wire

// ### tb/ctc_config_regs_checker.sv
`timescale 1ns/1ps
`default_nettype none
module ctc_config_regs_checker (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic wrStb,
   input wire logic rdStb,
   input wire logic [7:0] cmdCode,
   input wire logic [7:0] wrData,
   input wire ctc_pkg::ctc_margin_t marginReq,
   input wire logic enable,
   input wire logic outputUndervoltage,
   input wire logic [7:0] rdData,
   input wire logic rdValid,
   input wire logic rdErr,
   input wire logic [9:0] switchFreqKhz,
   input wire logic forcedContinuous,
   input wire logic softStartActive,
   input wire logic latchedOff,
   input wire logic [15:0] refScale
);
   import ctc_pkg::*;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);
   // A read request answered on the next cycle
   sequence s_read;
      rdStb ##1 rdValid;
   endsequence
   a_read_answer: assert property (rdStb |-> s_read) else $error("read not answered");
   a_answer_cause: assert property (rdValid |-> $past(rdStb)) else $error("answer without request");
   a_unmapped_zero: assert property (rdErr |-> rdValid && rdData == 8'h00) else $error("bad refusal");
   a_ramp_discont: assert property (softStartActive |-> !forcedContinuous) else $error("continuous in ramp");
   a_ramp_cause: assert property ($rose(softStartActive) |-> $past(enable)) else $error("ramp without enable");
   a_latch_quiet: assert property (latchedOff |-> !softStartActive) else $error("ramp while latched");
   a_freq_legal: assert property (switchFreqKhz inside {10'd250, 10'd300, 10'd400, 10'd500, 10'd600,
      10'd750, 10'd850, 10'd1000}) else $error("illegal frequency");
   a_slew_unit: assert property ($changed(refScale) |-> refScale == $past(refScale) + 16'h1 ||
      refScale == $past(refScale) - 16'h1) else $error("slew step not one unit");
   a_slew_spacing: assert property ($changed(refScale) |=> $stable(refScale) [*8]) else $error("steps too close");
endmodule // ctc_config_regs_checker
bind ctc_config_regs ctc_config_regs_checker u_chk (.clk(clk), .rst_b(rst_b), .wrStb(wrStb), .rdStb(rdStb),
   .cmdCode(cmdCode), .wrData(wrData), .marginReq(marginReq), .enable(enable),
   .outputUndervoltage(outputUndervoltage), .rdData(rdData), .rdValid(rdValid), .rdErr(rdErr),
   .switchFreqKhz(switchFreqKhz), .forcedContinuous(forcedContinuous), .softStartActive(softStartActive),
   .latchedOff(latchedOff), .refScale(refScale));
`default_nettype wire

// ### tb/ctc_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module ctc_host_model (
   input wire logic clk,
   output var logic wrStb,
   output var logic rdStb,
   output var logic [7:0] cmdCode,
   output var logic [7:0] wrData,
   input wire logic [7:0] rdData,
   input wire logic rdValid,
   input wire logic rdErr
);
   // Bus idle at time zero
   initial begin
      wrStb = 1'b0;
      rdStb = 1'b0;
      cmdCode = 8'h00;
      wrData = 8'h00;
   end
   // Single-byte write; lines scrambled once released
   task automatic write_byte(input logic [7:0] cmd, input logic [7:0] data);
      @(posedge clk);
      #1;
      cmdCode = cmd;
      wrData = data;
      wrStb = 1'b1;
      @(posedge clk);
      #1;
      wrStb = 1'b0;
      cmdCode = ~cmd;
      wrData = ~data;
   endtask
   // Single-byte read; answer stands from the taking edge, sampled 1 ns after it
   task automatic read_byte(input logic [7:0] cmd, output logic [7:0] data, output logic err);
      @(posedge clk);
      #1;
      cmdCode = cmd;
      rdStb = 1'b1;
      @(posedge clk);
      #1;
      rdStb = 1'b0;
      cmdCode = ~cmd;
      data = rdValid ? rdData : 8'hxx;
      err = rdValid ? rdErr : 1'bx;
   endtask
endmodule // ctc_host_model
`default_nettype wire

// ### tb/ctc_config_regs_tb.sv
`timescale 1ns/1ps
`default_nettype none
module ctc_config_regs_tb;
   import ctc_pkg::*;
   logic clk, rst_b, wrStb, rdStb, enable, outputUndervoltage, rdValid, rdErr;
   logic forcedContinuous, softStartActive, latchedOff, rdErrSeen;
   logic [7:0] cmdCode, wrData, rdData, rdSeen;
   logic [9:0] switchFreqKhz;
   logic [15:0] refScale;
   ctc_margin_t marginReq;
   int numErrors = 0;
   int checked = 0;
   ctc_config_regs u_dut (.clk(clk), .rst_b(rst_b), .wrStb(wrStb), .rdStb(rdStb), .cmdCode(cmdCode),
      .wrData(wrData), .marginReq(marginReq), .enable(enable), .outputUndervoltage(outputUndervoltage),
      .rdData(rdData), .rdValid(rdValid), .rdErr(rdErr), .switchFreqKhz(switchFreqKhz),
      .forcedContinuous(forcedContinuous), .softStartActive(softStartActive), .latchedOff(latchedOff),
      .refScale(refScale));
   ctc_host_model u_host (.clk(clk), .wrStb(wrStb), .rdStb(rdStb), .cmdCode(cmdCode), .wrData(wrData),
      .rdData(rdData), .rdValid(rdValid), .rdErr(rdErr));
   // Clock generator
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // Compare a seen value with its expectation
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         numErrors++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic report_and_stop;
      $display("Comparisons %0d, mismatches %0d", checked, numErrors);
      if (numErrors == 0 && checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   // Count cycles until the reference scale moves; a spent bound ends the run
   task automatic wait_change(input int bound, output int n);
      logic [15:0] old;
      old = refScale;
      n = 0;
      while (refScale === old && n < bound) begin
         @(posedge clk);
         #1;
         n++;
      end
      if (n == bound) begin
         numErrors++;
         report_and_stop();
      end
   endtask
   task automatic cycles(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   // Defaults of all four registers, the switch frequency and the reference scale
   task automatic test_reset_values;
      logic [7:0] exp [4] = '{8'h00, 8'h02, 8'h10, 8'h55};
      for (int i = 0; i < 4; i++) begin
         u_host.read_byte(8'hd2 + 8'(i), rdSeen, rdErrSeen);
         check({8'h00, rdSeen}, {8'h00, exp[i]});
      end
      check({6'h00, switchFreqKhz}, 16'd400);
      check(refScale, 16'd10000);
      $display("Done: reset values");
   endtask
   // Unsupported bits ignored, unmapped code refused
   task automatic test_masks;
      logic [7:0] exp [4] = '{8'h0f, 8'h07, 8'h1f, 8'hff};
      for (int i = 0; i < 4; i++) begin
         u_host.write_byte(8'hd2 + 8'(i), 8'hff);
         u_host.read_byte(8'hd2 + 8'(i), rdSeen, rdErrSeen);
         check({7'h00, rdErrSeen, rdSeen}, {8'h00, exp[i]});
      end
      u_host.write_byte(8'hd2, 8'h00);
      u_host.write_byte(8'hd6, 8'h5a);
      u_host.read_byte(8'hd6, rdSeen, rdErrSeen);
      check({7'h00, rdErrSeen, rdSeen}, 16'h0100);
      $display("Done: masks");
   endtask
   // Every frequency code
   task automatic test_freq;
      logic [9:0] khz [8] = '{10'd250, 10'd300, 10'd400, 10'd500, 10'd600, 10'd750, 10'd850, 10'd1000};
      for (int i = 0; i < 8; i++) begin
         u_host.write_byte(8'hd3, 8'(i));
         cycles(2);
         check({6'h00, switchFreqKhz}, {6'h00, khz[i]});
      end
      $display("Done: frequency");
   endtask
   // Trim write waits, then slews one unit per 4 us
   task automatic test_trim_slew;
      int n;
      u_host.write_byte(8'hd5, 8'h55);
      u_host.write_byte(8'hd4, 8'h11);
      cycles(4900);
      check(refScale, 16'd10000);
      wait_change(1000, n);
      check(refScale, 16'd10001);
      wait_change(1000, n);
      check(16'(n), 16'd400);
      $display("Done: trim slew");
   endtask
   // Margin low request turns the slew downward after the delay, same step interval
   task automatic test_margin;
      int n;
      marginReq = CTC_MARG_LOW;
      cycles(4900);
      check(refScale, 16'd10002);
      wait_change(1000, n);
      check(refScale, 16'd10001);
      wait_change(1000, n);
      check(16'(n), 16'd400);
      $display("Done: margin");
   endtask
   // 1 ms ramp, continuous after it, latch-off on undervoltage
   task automatic test_ramp_latch;
      int n;
      logic [15:0] ss;
      u_host.write_byte(8'hd2, 8'h03);
      enable = 1'b1;
      cycles(1);
      check({15'h0, softStartActive}, 16'h1);
      // New ramp select and hiccup response written mid-ramp must wait for the next start
      u_host.write_byte(8'hd2, 8'h0d);
      n = 2; // The write above took two ramp cycles
      while (softStartActive === 1'b1 && n < 110000) begin
         cycles(1);
         n++;
      end
      if (n == 110000) begin
         numErrors++;
         report_and_stop();
      end
      check(16'(n / 10), 16'd10000);
      check({15'h0, forcedContinuous}, 16'h1);
      outputUndervoltage = 1'b1;
      cycles(3);
      check({15'h0, latchedOff}, 16'h1);
      outputUndervoltage = 1'b0;
      enable = 1'b0;
      cycles(3);
      check({15'h0, latchedOff}, 16'h0);
      $display("Done: ramp and latch-off");
   endtask
   // Main sequence
   initial begin
      rst_b = 1'b0;
      enable = 1'b0;
      outputUndervoltage = 1'b0;
      marginReq = CTC_MARG_NONE;
      repeat (3) @(posedge clk);
      #1;
      rst_b = 1'b1;
      test_reset_values();
      test_masks();
      test_freq();
      test_trim_slew();
      test_margin();
      test_ramp_latch();
      report_and_stop();
   end
endmodule // ctc_config_regs_tb
`default_nettype wire
